// file: hdl/dac_channel_control.sv
// Register file, conversion start and output control of a two channel 12-bit converter.
// Assumes an AXI4-Lite master, an event network and DMA logic on aclk.
`timescale 1ns/1ps
`include "dac_channel_control_defs.svh"

//
// Contract
// - Channel 0 pin driven unless internally routed
// - Low power: off between, double conversion time
// - Global enable gates whole converter except vref_onehot and the DMA requests
// - Channel config: solo0, solo1, dual, reserved
// - Channel 1 event start needs updated data
// - Channel 0 event start needs updated data
// - Reference select: 1V, supply, port A, B
// - Left align bit selects data layout
// - Split bit gives channel 1 next event
// - Three bit field picks event channel
// - Empty flag marks register ready for data
// - Write while full overwrites pending value
// - Empty flag is the DMA request
// - Right layout: low byte, high nibble
// - Left layout: high byte, low upper nibble
// - Reserved bits read zero, written zero
// - Internal route feeds comparator, drops pin
// - Without event trigger, write starts conversion
module dac_channel_control #(
    parameter int ADDR_W = 8,
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event channels, one cycle pulses on aclk
    input wire logic [7:0] evt_in,
    // Analog controls
    output logic out0_pin_drive,
    output logic out1_pin_drive,
    output logic internal_route_en,
    output logic [3:0] vref_onehot,
    output logic analog0_on,
    output logic analog1_on,
    // Conversion values
    output logic [11:0] conv0_value,
    output logic [11:0] conv1_value,
    output logic conv0_start,
    output logic conv1_start,
    // DMA requests
    output logic dma0_req,
    output logic dma1_req
);

    initial begin
        if (ADDR_W < 7 || ADDR_W > 32 || CONV_CYCLES < 1) begin
            $error("dac_channel_control parameters out of range");
        end
    end

    // ----------------------------------------
    // Layout helpers
    // ----------------------------------------
    function automatic logic [11:0] assemble(input logic [7:0] hold, input logic [7:0] hi,
                                             input logic left);
        assemble = left ? {hi, hold[7:4]} : {hi[3:0], hold};
    endfunction

    function automatic logic [7:0] data_byte(input logic [11:0] value, input logic is_hi,
                                             input logic left);
        if (left) begin
            data_byte = is_hi ? value[11:4] : {value[3:0], 4'h0};
        end else begin
            data_byte = is_hi ? {4'h0, value[11:8]} : value[7:0];
        end
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] enable_power_config_reg;
    logic [7:0] channel_trigger_config_reg;
    logic [7:0] reference_align_config_reg;
    logic [7:0] event_source_config_reg;
    logic [1:0] empty_reg;
    logic [1:0] pending_reg;
    logic [11:0] value_reg [2];
    logic [7:0] hold_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [5:0] aw_idx_reg;
    logic [7:0] wdata_reg;
    logic wstrb_reg;
    logic do_write;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic wr_hit;
    logic [1:0] wr_lo;
    logic [1:0] wr_hi;
    logic [1:0] active;
    logic [1:0] trig_en;
    logic [1:0] evt_hit;
    logic [1:0] start;
    logic [1:0] busy;
    logic [2:0] src0;
    logic [2:0] src1;
    logic enable;
    logic low_power;
    logic left;

    assign enable = enable_power_config_reg[`BIT_ENABLE];
    assign low_power = enable_power_config_reg[`BIT_LOW_POWER];
    assign left = reference_align_config_reg[`BIT_LEFT];

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    // Address and data are taken in either order; one write is served at a time
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_idx = aw_idx_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_idx_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[7:2];
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        case (wr_idx)
            `IDX_ENABLE_POWER, `IDX_CHAN_TRIG, `IDX_REF_ALIGN, `IDX_EVT_SRC,
            `IDX_EMPTY_FLAGS, `IDX_CH0_LO, `IDX_CH0_HI, `IDX_CH1_LO, `IDX_CH1_HI: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Lane 0 carries every register; a write without it changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_power_config_reg <= `RST_CONFIG;
            channel_trigger_config_reg <= `RST_CONFIG;
            reference_align_config_reg <= `RST_CONFIG;
            event_source_config_reg <= `RST_CONFIG;
        end else if (do_write && wstrb_reg) begin
            case (wr_idx)
                `IDX_ENABLE_POWER: enable_power_config_reg <= wdata_reg & `MASK_ENABLE_POWER;
                `IDX_CHAN_TRIG: channel_trigger_config_reg <= wdata_reg & `MASK_CHAN_TRIG;
                `IDX_REF_ALIGN: reference_align_config_reg <= wdata_reg & `MASK_REF_ALIGN;
                `IDX_EVT_SRC: event_source_config_reg <= wdata_reg & `MASK_EVT_SRC;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Data registers and hold buffer
    // ----------------------------------------
    always_comb begin
        wr_lo = 2'b00;
        wr_hi = 2'b00;
        if (do_write && wstrb_reg) begin
            wr_lo[0] = (wr_idx == `IDX_CH0_LO);
            wr_lo[1] = (wr_idx == `IDX_CH1_LO);
            wr_hi[0] = (wr_idx == `IDX_CH0_HI);
            wr_hi[1] = (wr_idx == `IDX_CH1_HI);
        end
    end

    // One hold byte serves both channels, as the low byte of either waits in it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_reg <= '0;
        end else if (wr_lo != 2'b00) begin
            hold_reg <= left ? {wdata_reg[7:4], 4'h0} : wdata_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_reg[0] <= '0;
            value_reg[1] <= '0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (wr_hi[n]) begin
                    value_reg[n] <= assemble(hold_reg, wdata_reg, left);
                end
            end
        end
    end

    // A commit in the start cycle wins, so fresh data is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_reg <= 2'b00;
            empty_reg <= 2'b00;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (wr_hi[n]) begin
                    pending_reg[n] <= 1'b1;
                    empty_reg[n] <= 1'b0;
                end else if (start[n]) begin
                    pending_reg[n] <= 1'b0;
                    empty_reg[n] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Conversion start
    // ----------------------------------------
    assign active[0] = enable && (channel_trigger_config_reg[6:5] == `CHCFG_SOLO0 ||
                                  channel_trigger_config_reg[6:5] == `CHCFG_DUAL);
    assign active[1] = enable && (channel_trigger_config_reg[6:5] == `CHCFG_SOLO1 ||
                                  channel_trigger_config_reg[6:5] == `CHCFG_DUAL);
    assign trig_en[0] = channel_trigger_config_reg[`BIT_EVT0];
    assign trig_en[1] = channel_trigger_config_reg[`BIT_EVT1];
    assign src0 = event_source_config_reg[2:0];
    assign src1 = event_source_config_reg[`BIT_EVT_SPLIT] ? src0 + 3'd1 : src0;
    assign evt_hit[0] = evt_in[src0];
    assign evt_hit[1] = evt_in[src1];

    always_comb begin
        for (int n = 0; n < 2; n++) begin
            start[n] = active[n] && pending_reg[n] && !busy[n] &&
                       (trig_en[n] ? evt_hit[n] : 1'b1);
        end
    end

    conv_timer #(
        .CYCLES(CONV_CYCLES)
    ) timer0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start[0]),
        .double_time(low_power),
        .busy(busy[0])
    );

    conv_timer #(
        .CYCLES(CONV_CYCLES)
    ) timer1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start[1]),
        .double_time(low_power),
        .busy(busy[1])
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv0_value <= '0;
            conv1_value <= '0;
            conv0_start <= 1'b0;
            conv1_start <= 1'b0;
        end else begin
            conv0_start <= start[0];
            conv1_start <= start[1];
            if (start[0]) begin
                conv0_value <= value_reg[0];
            end
            if (start[1]) begin
                conv1_value <= value_reg[1];
            end
        end
    end

    assign dma0_req = empty_reg[0];
    assign dma1_req = empty_reg[1];

    // ----------------------------------------
    // Analog controls
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out0_pin_drive <= 1'b0;
            out1_pin_drive <= 1'b0;
            internal_route_en <= 1'b0;
            analog0_on <= 1'b0;
            analog1_on <= 1'b0;
        end else begin
            out0_pin_drive <= active[0] && enable_power_config_reg[`BIT_OUT0_PIN] &&
                              !enable_power_config_reg[`BIT_INT_ROUTE];
            out1_pin_drive <= active[1] && enable_power_config_reg[`BIT_OUT1_PIN];
            internal_route_en <= active[0] && enable_power_config_reg[`BIT_INT_ROUTE];
            analog0_on <= active[0] && (low_power ? busy[0] : 1'b1);
            analog1_on <= active[1] && (low_power ? busy[1] : 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vref_onehot <= 4'h1;
        end else begin
            case (reference_align_config_reg[4:3])
                `VREF_INT_ONE_VOLT: vref_onehot <= 4'h1;
                `VREF_ANALOG_SUPPLY: vref_onehot <= 4'h2;
                `VREF_EXT_PORT_A: vref_onehot <= 4'h4;
                `VREF_EXT_PORT_B: vref_onehot <= 4'h8;
                default: vref_onehot <= 4'h1;
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    assign rd_idx = s_axi_araddr[7:2];
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            `IDX_ENABLE_POWER: rd_byte = enable_power_config_reg;
            `IDX_CHAN_TRIG: rd_byte = channel_trigger_config_reg;
            `IDX_REF_ALIGN: rd_byte = reference_align_config_reg;
            `IDX_EVT_SRC: rd_byte = event_source_config_reg;
            `IDX_EMPTY_FLAGS: rd_byte = {6'h00, empty_reg};
            `IDX_CH0_LO: rd_byte = data_byte(value_reg[0], 1'b0, left);
            `IDX_CH0_HI: rd_byte = data_byte(value_reg[0], 1'b1, left);
            `IDX_CH1_LO: rd_byte = data_byte(value_reg[1], 1'b0, left);
            `IDX_CH1_HI: rd_byte = data_byte(value_reg[1], 1'b1, left);
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Channel 0 conversion length, judged when busy falls; a counter avoids long repetitions
    logic [31:0] busy_len_reg;
    logic dbl_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_len_reg <= '0;
            dbl_reg <= 1'b0;
        end else if (start[0]) begin
            busy_len_reg <= '0;
            dbl_reg <= low_power;
        end else if (busy[0]) begin
            busy_len_reg <= busy_len_reg + 32'd1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PIN0_ROUTE: assert property (
        out0_pin_drive |-> !internal_route_en && $past(enable_power_config_reg[`BIT_OUT0_PIN]))
        else $error("Channel 0 pin driven while routed inside");
    AST_LOW_POWER_TIME: assert property (
        $fell(busy[0]) |-> busy_len_reg == 32'(dbl_reg ? 2 * CONV_CYCLES : CONV_CYCLES))
        else $error("Low power conversion not twice as long");
    AST_DISABLED_QUIET: assert property (
        !enable |-> start == 2'b00 ##1 !conv0_start && !conv1_start)
        else $error("Conversion started while disabled");
    AST_RESERVED_CFG: assert property (
        channel_trigger_config_reg[6:5] == 2'b11 |-> start == 2'b00)
        else $error("Conversion started in reserved channel config");
    AST_EVT_START1: assert property (
        start[1] && trig_en[1] |-> evt_hit[1] && pending_reg[1] ##1 conv1_start)
        else $error("Channel 1 event start without event or data");
    AST_EVT_START0: assert property (
        start[0] && trig_en[0] |-> evt_hit[0] && pending_reg[0] ##1 conv0_start)
        else $error("Channel 0 event start without event or data");
    AST_SPLIT_SOURCE: assert property (
        event_source_config_reg[3] |-> src1 == event_source_config_reg[2:0] + 3'd1)
        else $error("Channel 1 event source not one above");
    AST_COMMIT_EMPTY: assert property (
        wr_hi[0] |=> !empty_reg[0] && pending_reg[0] && dma0_req == 1'b0)
        else $error("Commit did not clear channel 0 empty flag");
    AST_START_EMPTY: assert property (
        start[0] && !wr_hi[0] |=> empty_reg[0] && conv0_value == $past(value_reg[0]))
        else $error("Start did not take value and set empty flag");
    AST_LEFT_LOW_READ: assert property (
        s_axi_arvalid && s_axi_arready && rd_idx == `IDX_CH0_LO && left |=>
        s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[7:4] == $past(value_reg[0][3:0]))
        else $error("Left aligned low byte read wrong");
    AST_OVERWRITE: assert property (
        wr_hi[1] && !empty_reg[1] |=> value_reg[1] == $past(assemble(hold_reg, wdata_reg, left)))
        else $error("Pending channel 1 value not replaced");

    COV_AUTO_START: cover property (wr_hi[0] ##[1:3] conv0_start);
    COV_EVT_START: cover property (trig_en[1] && start[1]);
    COV_LOW_POWER: cover property (low_power && start[0]);
    COV_OVERWRITE: cover property (wr_hi[0] && pending_reg[0]);

endmodule

// file: hdl/dac_channel_control_defs.svh
// Register indices, field positions, reset values and timing of the converter control.
// Assumes inclusion by bare name from the design files.
`ifndef DAC_CHANNEL_CONTROL_DEFS_SVH
`define DAC_CHANNEL_CONTROL_DEFS_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define IDX_ENABLE_POWER 6'h00
`define IDX_CHAN_TRIG 6'h01
`define IDX_REF_ALIGN 6'h02
`define IDX_EVT_SRC 6'h03
`define IDX_EMPTY_FLAGS 6'h05
`define IDX_CH0_LO 6'h18
`define IDX_CH0_HI 6'h19
`define IDX_CH1_LO 6'h1a
`define IDX_CH1_HI 6'h1b

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define MASK_ENABLE_POWER 8'h1f
`define MASK_CHAN_TRIG 8'h63
`define MASK_REF_ALIGN 8'h19
`define MASK_EVT_SRC 8'h0f
`define RST_CONFIG 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_ENABLE 0
`define BIT_LOW_POWER 1
`define BIT_OUT0_PIN 2
`define BIT_OUT1_PIN 3
`define BIT_INT_ROUTE 4
`define BIT_EVT0 0
`define BIT_EVT1 1
`define CHCFG_LSB 5
`define VREF_LSB 3
`define BIT_LEFT 0
`define BIT_EVT_SPLIT 3

// ----------------------------------------
// Field codes
// ----------------------------------------
`define CHCFG_SOLO0 2'b00
`define CHCFG_SOLO1 2'b01
`define CHCFG_DUAL 2'b10
`define VREF_INT_ONE_VOLT 2'b00
`define VREF_ANALOG_SUPPLY 2'b01
`define VREF_EXT_PORT_A 2'b10
`define VREF_EXT_PORT_B 2'b11
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hdl/dac_channel_control_pkg.sv
// Types shared by the converter control modules.
// Assumes nothing of its surroundings.
package dac_channel_control_pkg;

    typedef enum logic {
        CONV_IDLE,
        CONV_RUN
    } conv_state_t;

endpackage

// file: hdl/conv_timer.sv
// Conversion time counter for one converter channel.
// Assumes start is raised only while busy is low.
`timescale 1ns/1ps

module conv_timer #(
    parameter int CYCLES = 100
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic start,
    input wire logic double_time,
    // Status
    output logic busy
);

    localparam int CW = $clog2(2 * CYCLES + 1);

    initial begin
        if (CYCLES < 1) begin
            $error("conv_timer needs CYCLES of at least one");
        end
    end

    dac_channel_control_pkg::conv_state_t state_reg;
    logic [CW-1:0] count_reg;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Doubling is latched at the start, so a later mode change spares the running conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= dac_channel_control_pkg::CONV_IDLE;
            count_reg <= '0;
        end else begin
            case (state_reg)
                dac_channel_control_pkg::CONV_IDLE: begin
                    if (start) begin
                        state_reg <= dac_channel_control_pkg::CONV_RUN;
                        count_reg <= double_time ? CW'(2 * CYCLES - 1) : CW'(CYCLES - 1);
                    end
                end
                dac_channel_control_pkg::CONV_RUN: begin
                    if (count_reg == '0) begin
                        state_reg <= dac_channel_control_pkg::CONV_IDLE;
                    end else begin
                        count_reg <= count_reg - CW'(1);
                    end
                end
                default: begin
                    state_reg <= dac_channel_control_pkg::CONV_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_reg == dac_channel_control_pkg::CONV_RUN);

endmodule

// file: testbench/evt_source_model.sv
// Event network stand-in: one-cycle event pulses.
// Assumes fire is held for one aclk cycle.
`timescale 1ns/1ps
module evt_source_model (
    // Clock
    input wire logic aclk,
    // Request
    input wire logic fire,
    input wire logic [2:0] chan,
    // Events
    output logic [7:0] evt_in
);
    always_ff @(posedge aclk) begin
        evt_in <= fire ? (8'h01 << chan) : 8'h00;
    end
endmodule

// file: testbench/dac_channel_control_tb.sv
// Self-checking bench for the converter control.
// Assumes the design, its header and the event model.
`timescale 1ns/1ps
`include "dac_channel_control_defs.svh"
module dac_channel_control_tb;
logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
logic arv = 1'b0, rready = 1'b0, fire = 1'b0, h;
logic [7:0] awaddr = 8'h00, araddr = 8'h00, evt;
logic [31:0] wdata = 32'h0, rdata;
logic [2:0] chan = 3'h0;
logic [1:0] bresp, rresp;
logic [3:0] vref;
logic [11:0] v0, v1, v;
logic awr, wr_rdy, bvalid, arready, rvalid, out0, out1, route, an0, an1, st0, st1, dma0, dma1;
int mismatches = 0, total_checks = 0, cyc = 0;
always #5 aclk = ~aclk;
evt_source_model evm (.aclk(aclk), .fire(fire), .chan(chan), .evt_in(evt));
dac_channel_control #(.CONV_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .evt_in(evt), .out0_pin_drive(out0), .out1_pin_drive(out1), .internal_route_en(route),
    .vref_onehot(vref), .analog0_on(an0), .analog1_on(an1), .conv0_value(v0),
    .conv1_value(v1), .conv0_start(st0), .conv1_start(st1), .dma0_req(dma0), .dma1_req(dma1));
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
        mismatches++;
        $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
        mismatches++;
        tally_and_finish;
    end
end
task automatic wr(input logic [5:0] i, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wr_rdy) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, 32'h0);
endtask
task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] r);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, {24'h0, e});
    chk("rresp", {30'h0, rresp}, {30'h0, r});
endtask
// Watches eight edges for a start pulse on one channel
task automatic grab(input logic ch);
    h = 1'b0;
    repeat (8) begin
        @(posedge aclk);
        if (!h && (ch ? st1 : st0) === 1'b1) begin
            h = 1'b1;
            v = ch ? v1 : v0;
        end
    end
endtask
task automatic ev(input logic [2:0] c);
    @(posedge aclk);
    chan <= c;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
endtask
task automatic s_regs;
    rd(`IDX_EMPTY_FLAGS, 8'h00, 2'b00);
    rd(6'h3f, 8'h00, 2'b10);
    wr(`IDX_CHAN_TRIG, 8'hff);
    rd(`IDX_CHAN_TRIG, 8'h63, 2'b00);
    wr(`IDX_CHAN_TRIG, 8'h00);
endtask
task automatic s_pin;
    wr(`IDX_ENABLE_POWER, 8'h05);
    repeat (3) @(posedge aclk);
    chk("out0", out0, 1);
    chk("an0", an0, 1);
    chk("an1", an1, 0);
    wr(`IDX_ENABLE_POWER, 8'h15);
    repeat (3) @(posedge aclk);
    chk("out0", out0, 0);
    chk("route", route, 1);
endtask
task automatic s_right;
    wr(`IDX_CH0_LO, 8'h34);
    wr(`IDX_CH0_HI, 8'h12);
    grab(1'b0);
    chk("v0", {h, v}, 13'h1234);
    chk("dma0", dma0, 1);
    rd(`IDX_EMPTY_FLAGS, 8'h01, 2'b00);
endtask
task automatic s_event;
    wr(`IDX_CHAN_TRIG, 8'h42);
    wr(`IDX_EVT_SRC, 8'h0b);
    wr(`IDX_CH1_LO, 8'h56);
    wr(`IDX_CH1_HI, 8'h07);
    wr(`IDX_CH1_HI, 8'h09);
    chk("dma1", dma1, 0);
    ev(3'h3);
    grab(1'b1);
    chk("st1", h, 0);
    ev(3'h4);
    grab(1'b1);
    chk("v1", {h, v}, 13'h1956);
    chk("an1", an1, 1);
    chk("dma1", dma1, 1);
    ev(3'h4);
    grab(1'b1);
    chk("st1", h, 0);
endtask
task automatic s_left;
    wr(`IDX_REF_ALIGN, 8'h19);
    wr(`IDX_CHAN_TRIG, 8'h00);
    wr(`IDX_CH0_LO, 8'ha7);
    wr(`IDX_CH0_HI, 8'hbc);
    grab(1'b0);
    chk("v0", {h, v}, 13'h1bca);
    rd(`IDX_CH0_LO, 8'ha0, 2'b00);
    chk("vref", vref, 4'h8);
    wr(`IDX_CH0_LO, 8'h00);
    wr(`IDX_CH0_HI, 8'h5e);
    grab(1'b0);
    chk("v0", {h, v}, 13'h15e0);
endtask
task automatic s_lowpow;
    wr(`IDX_CHAN_TRIG, 8'h41);
    wr(`IDX_ENABLE_POWER, 8'h1f);
    repeat (3) @(posedge aclk);
    chk("an0", an0, 0);
    chk("an1", an1, 0);
    chk("out1", out1, 1);
    wr(`IDX_CH0_HI, 8'h11);
    grab(1'b0);
    chk("st0", h, 0);
    ev(3'h3);
    grab(1'b0);
    chk("v0", {h, v}, 13'h1110);
    chk("an0", an0, 1);
    repeat (4) @(posedge aclk);
    chk("an0", an0, 0);
endtask
initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs;
    s_pin;
    s_right;
    s_event;
    s_left;
    s_lowpow;
    tally_and_finish;
end
endmodule
